//--- bcd_digit.sv
// one decade counter stage with clear and wrap pulse
`timescale 1ns/1ns
module bcd_digit
    import stopwatch_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] LAST = 4'h9
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic clear_in,
    input wire logic step_in,
    output logic [WIDTH-1:0] value_out,
    output logic wrap_out
);
    logic [WIDTH-1:0] value_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            value_q <= '0;
        end else if (ce_in) begin
            if (clear_in) begin
                value_q <= '0;
            end else if (step_in) begin
                value_q <= (value_q == LAST) ? '0 : WIDTH'(value_q + 1'b1);
            end
        end
    end

    assign value_out = value_q;
    assign wrap_out = step_in && (value_q == LAST) && !clear_in;

endmodule // bcd_digit

//--- stopwatch_pkg.sv
// constants and types shared by the stopwatch timer block
package stopwatch_pkg;

    localparam int AW = 18;
    localparam int DW = 32;
    localparam int DIGIT_W = 4;

    // register indices; byte address is four times the index
    localparam logic [15:0] CTRL_IDX = 16'hFF7C;
    localparam logic [15:0] HUND_IDX = 16'hFF7D;
    localparam logic [15:0] TENTH_IDX = 16'hFF7E;
    localparam logic [15:0] IRQ_EN_IDX = 16'hFFE7;
    localparam logic [15:0] IRQ_FLAG_IDX = 16'hFFF7;

    localparam logic [AW-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    localparam logic [AW-1:0] HUND_ADDR = {HUND_IDX, 2'b00};
    localparam logic [AW-1:0] TENTH_ADDR = {TENTH_IDX, 2'b00};
    localparam logic [AW-1:0] IRQ_EN_ADDR = {IRQ_EN_IDX, 2'b00};
    localparam logic [AW-1:0] IRQ_FLAG_ADDR = {IRQ_FLAG_IDX, 2'b00};

    // field positions
    localparam int RUN_BIT = 0;
    localparam int CLEAR_BIT = 1;
    localparam int TENTH_IRQ_BIT = 0;
    localparam int ONE_SEC_IRQ_BIT = 1;

    // reset values
    localparam logic RUN_RST = 1'b0;
    localparam logic [DIGIT_W-1:0] DIGIT_RST = 4'h0;
    localparam logic [1:0] IRQ_RST = 2'h0;

    // count pattern
    localparam logic [DIGIT_W-1:0] DIGIT_LAST = 4'h9;
    localparam logic [1:0] SHORT_STEP = 2'h2;
    localparam logic [1:0] LONG_STEP = 2'h3;
    localparam logic [DIGIT_W-1:0] LONG_DECADE_FROM = 4'h4;
    localparam logic [8:0] TICKS_PER_SECOND = 9'h100;

    typedef struct packed {
        logic read;
        logic write;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic [3:0] be;
    } av_req_t;

    typedef struct packed {
        logic one_sec;
        logic tenth_sec;
    } irq_bits_t;

    typedef enum logic [0:0] {
        BUS_WAIT = 1'b0,
        BUS_DONE = 1'b1
    } bus_state_t;

endpackage

//--- stopwatch_timer.sv
// stopwatch timer: two cascaded bcd digits, control, interrupts, avalon slave
`timescale 1ns/1ns
//
// Contract
// - two cascaded 4-bit bcd digits, low wrap steps high digit
// - low digit steps every two or three 256 Hz ticks
// - per high decade four 25-tick and six 26-tick wraps, one second
// - low wrap sets tenth flag, high wrap sets one-second flag
// - flags set whatever the enable bits hold
// - two read/write enable bits, cleared by reset
// - two sticky flags, write one clears, reset clears
// - digits readable, writes to them ignored
// - reset clears both digits
// - writing one to clear bit zeroes digits, reads back zero
// - clear written with run bit one resumes from zero at once, else holds
// - run bit read/write, one runs, zero stops, reset clears
// - while stopped digits hold; restart resumes from them
module stopwatch_timer
    import stopwatch_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic CE_IN,
    input wire logic TICK_256_IN,
    input wire logic [AW-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [DW-1:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [DW-1:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    output logic IRQ_OUT
);
    av_req_t req;
    bus_state_t bus_q;
    logic [DW-1:0] rdata_q;
    logic run_q;
    irq_bits_t irq_en_q;
    irq_bits_t irq_flag_q;
    irq_bits_t irq_flag_d;
    irq_bits_t irq_set;
    irq_bits_t irq_clr;
    logic [1:0] pre_q;
    logic [1:0] step_len;
    logic [1:0] pre_next;
    logic tick_adv;
    logic lo_step;
    logic lo_wrap;
    logic hi_wrap;
    logic [DIGIT_W-1:0] lo_digit;
    logic [DIGIT_W-1:0] hi_digit;
    logic wr_commit;
    logic wr_ctrl;
    logic wr_en;
    logic wr_flag;
    logic clear_cmd;

    assign req = '{read: AVS_READ_IN, write: AVS_WRITE_IN, addr: AVS_ADDRESS_IN,
                   wdata: AVS_WRITEDATA_IN, be: AVS_BYTEENABLE_IN};

    // bus slave: one wait state per access
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            bus_q <= BUS_WAIT;
        end else if (CE_IN) begin
            case (bus_q)
                BUS_WAIT: begin
                    if (req.read || req.write) begin
                        bus_q <= BUS_DONE;
                    end
                end
                BUS_DONE: begin
                    bus_q <= BUS_WAIT;
                end
                default: begin
                    bus_q <= BUS_WAIT;
                end
            endcase
        end
    end

    assign AVS_WAITREQUEST_OUT = (req.read || req.write) && ((bus_q != BUS_DONE) || !CE_IN);
    assign wr_commit = CE_IN && req.write && (bus_q == BUS_DONE) && req.be[0];
    assign wr_ctrl = wr_commit && (req.addr == CTRL_ADDR);
    assign wr_en = wr_commit && (req.addr == IRQ_EN_ADDR);
    assign wr_flag = wr_commit && (req.addr == IRQ_FLAG_ADDR);
    assign clear_cmd = wr_ctrl && req.wdata[CLEAR_BIT];

    // read data captured in the wait cycle, stands at the done edge
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            rdata_q <= '0;
        end else if (CE_IN && req.read && (bus_q == BUS_WAIT)) begin
            case (req.addr)
                CTRL_ADDR: rdata_q <= {{(DW-1){1'b0}}, run_q};
                HUND_ADDR: rdata_q <= {{(DW-DIGIT_W){1'b0}}, lo_digit};
                TENTH_ADDR: rdata_q <= {{(DW-DIGIT_W){1'b0}}, hi_digit};
                IRQ_EN_ADDR: rdata_q <= {{(DW-2){1'b0}}, irq_en_q};
                IRQ_FLAG_ADDR: rdata_q <= {{(DW-2){1'b0}}, irq_flag_q};
                default: rdata_q <= '0;
            endcase
        end
    end

    assign AVS_READDATA_OUT = rdata_q;

    // run control
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            run_q <= RUN_RST;
        end else if (CE_IN && wr_ctrl) begin
            run_q <= req.wdata[RUN_BIT];
        end
    end

    // step length: odd digits take three ticks, digit zero too in long decades
    always_comb begin
        step_len = SHORT_STEP;
        if (lo_digit[0] || ((lo_digit == DIGIT_RST) && (hi_digit >= LONG_DECADE_FROM))) begin
            step_len = LONG_STEP;
        end
    end

    assign tick_adv = run_q && TICK_256_IN;
    assign pre_next = 2'(pre_q + 2'h1);
    assign lo_step = tick_adv && (pre_next == step_len) && !clear_cmd;

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            pre_q <= 2'h0;
        end else if (CE_IN) begin
            if (clear_cmd) begin
                pre_q <= 2'h0;
            end else if (tick_adv) begin
                pre_q <= (pre_next == step_len) ? 2'h0 : pre_next;
            end
        end
    end

    bcd_digit #(
        .WIDTH(DIGIT_W),
        .LAST(DIGIT_LAST)
    ) u_low_digit (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .ce_in(CE_IN),
        .clear_in(clear_cmd),
        .step_in(lo_step),
        .value_out(lo_digit),
        .wrap_out(lo_wrap)
    );

    bcd_digit #(
        .WIDTH(DIGIT_W),
        .LAST(DIGIT_LAST)
    ) u_high_digit (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .ce_in(CE_IN),
        .clear_in(clear_cmd),
        .step_in(lo_wrap),
        .value_out(hi_digit),
        .wrap_out(hi_wrap)
    );

    // interrupt enables
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            irq_en_q <= IRQ_RST;
        end else if (CE_IN && wr_en) begin
            irq_en_q <= req.wdata[1:0];
        end
    end

    // sticky flags; a set in the clearing cycle wins
    always_comb begin
        irq_set = '{one_sec: hi_wrap, tenth_sec: lo_wrap};
        irq_clr = wr_flag ? irq_bits_t'(req.wdata[1:0]) : irq_bits_t'(2'h0);
        irq_flag_d = (irq_flag_q & ~irq_clr) | irq_set;
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            irq_flag_q <= IRQ_RST;
        end else if (CE_IN) begin
            irq_flag_q <= irq_flag_d;
        end
    end

    assign IRQ_OUT = |(irq_flag_q & irq_en_q);

    // helper: advancing ticks since reset, clear or the last high wrap
    logic [8:0] tick_cnt_q;
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            tick_cnt_q <= 9'h000;
        end else if (CE_IN) begin
            if (clear_cmd) begin
                tick_cnt_q <= 9'h000;
            end else if (hi_wrap) begin
                tick_cnt_q <= 9'h000;
            end else if (tick_adv) begin
                tick_cnt_q <= 9'(tick_cnt_q + 9'h001);
            end
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN || !CE_IN);

    property p_digits_bcd;
        (lo_digit <= DIGIT_LAST) && (hi_digit <= DIGIT_LAST);
    endproperty
    a_digits_bcd: assert property (p_digits_bcd) else $error("digit left bcd range");

    property p_high_carry;
        lo_wrap ##1 CE_IN |-> hi_digit == (($past(hi_digit) == DIGIT_LAST) ? 4'h0
                                          : 4'($past(hi_digit) + 4'h1));
    endproperty
    a_high_carry: assert property (p_high_carry) else $error("high digit missed carry");

    property p_step_len;
        lo_step |-> (pre_q == 2'h1) || (pre_q == 2'h2);
    endproperty
    a_step_len: assert property (p_step_len) else $error("low digit step not 2 or 3");

    property p_one_second;
        hi_wrap |-> tick_cnt_q == 9'(TICKS_PER_SECOND - 9'h001);
    endproperty
    a_one_second: assert property (p_one_second) else $error("second not 256 ticks");

    property p_tenth_flag;
        lo_wrap |=> irq_flag_q.tenth_sec;
    endproperty
    a_tenth_flag: assert property (p_tenth_flag) else $error("tenth flag not set");

    property p_sec_flag_masked;
        (hi_wrap && !irq_en_q.one_sec) |=> irq_flag_q.one_sec;
    endproperty
    a_sec_flag_masked: assert property (p_sec_flag_masked) else $error("masked flag not set");

    property p_enable_write;
        wr_en |=> irq_en_q == $past(req.wdata[1:0]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");

    property p_flag_clear;
        (wr_flag && req.wdata[TENTH_IRQ_BIT] && !lo_wrap) |=> !irq_flag_q.tenth_sec;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_digit_write_ignored;
        (wr_commit && (req.addr == HUND_ADDR) && !lo_step) |=> $stable(lo_digit);
    endproperty
    a_digit_write_ignored: assert property (p_digit_write_ignored) else $error("digit written");

    property p_clear_digits;
        clear_cmd |=> (lo_digit == 4'h0) && (hi_digit == 4'h0) && (pre_q == 2'h0);
    endproperty
    a_clear_digits: assert property (p_clear_digits) else $error("clear left digits");

    property p_ctrl_read;
        (req.read && (req.addr == CTRL_ADDR) && bus_q == BUS_WAIT) |=>
            AVS_READDATA_OUT == {31'h0, $past(run_q)};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

    property p_stopped_hold;
        (!run_q && !clear_cmd) |=> $stable(lo_digit) && $stable(hi_digit);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold) else $error("digits moved while stopped");

    property p_irq_level;
        IRQ_OUT == ((irq_flag_q.one_sec && irq_en_q.one_sec)
                    || (irq_flag_q.tenth_sec && irq_en_q.tenth_sec));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_bus_answer;
        ((req.read || req.write) && (bus_q == BUS_WAIT)) |=> !AVS_WAITREQUEST_OUT;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    property p_run_write;
        wr_ctrl |=> run_q == $past(req.wdata[RUN_BIT]);
    endproperty
    a_run_write: assert property (p_run_write) else $error("run bit write lost");

    property p_clear_zero_noop;
        (wr_ctrl && !req.wdata[CLEAR_BIT] && !lo_step) |=> $stable(lo_digit) && $stable(hi_digit);
    endproperty
    a_clear_zero_noop: assert property (p_clear_zero_noop) else $error("zero clear acted");

    property p_tenth_write_ignored;
        (wr_commit && (req.addr == TENTH_ADDR) && !lo_wrap) |=> $stable(hi_digit);
    endproperty
    a_tenth_write_ignored: assert property (p_tenth_write_ignored) else $error("digit written");

    property p_sec_flag;
        hi_wrap |=> irq_flag_q.one_sec;
    endproperty
    a_sec_flag: assert property (p_sec_flag) else $error("second flag not set");

    property p_tenth_flag_masked;
        (lo_wrap && !irq_en_q.tenth_sec) |=> irq_flag_q.tenth_sec;
    endproperty
    a_tenth_flag_masked: assert property (p_tenth_flag_masked) else $error("masked flag lost");

    property p_sec_flag_clear;
        (wr_flag && req.wdata[ONE_SEC_IRQ_BIT] && !hi_wrap) |=> !irq_flag_q.one_sec;
    endproperty
    a_sec_flag_clear: assert property (p_sec_flag_clear) else $error("second flag kept");

    property p_flag_zero_write;
        (wr_flag && !req.wdata[ONE_SEC_IRQ_BIT] && irq_flag_q.one_sec) |=> irq_flag_q.one_sec;
    endproperty
    a_flag_zero_write: assert property (p_flag_zero_write) else $error("zero write cleared");

    property p_low_wrap_zero;
        lo_wrap |=> lo_digit == DIGIT_RST;
    endproperty
    a_low_wrap_zero: assert property (p_low_wrap_zero) else $error("low wrap not zero");

    property p_low_step;
        lo_step |=> lo_digit == (($past(lo_digit) == DIGIT_LAST) ? DIGIT_RST
                                 : 4'($past(lo_digit) + 4'h1));
    endproperty
    a_low_step: assert property (p_low_step) else $error("low digit step wrong");

    property p_enable_hold;
        !wr_en |=> $stable(irq_en_q);
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("enable moved");

    property p_digit_read;
        (req.read && (req.addr == HUND_ADDR) && (bus_q == BUS_WAIT)) |=>
            AVS_READDATA_OUT == {28'h0, $past(lo_digit)};
    endproperty
    a_digit_read: assert property (p_digit_read) else $error("digit readback wrong");

    property p_stopped_prescaler;
        (!run_q && !clear_cmd) |=> $stable(pre_q);
    endproperty
    a_stopped_prescaler: assert property (p_stopped_prescaler) else $error("prescaler moved");

    c_tenth_wrap: cover property (lo_wrap);
    c_second_wrap: cover property (hi_wrap);
    c_clear_running: cover property (clear_cmd && run_q);
    c_set_beats_clear: cover property (wr_flag && lo_wrap && req.wdata[TENTH_IRQ_BIT]);

endmodule // stopwatch_timer

//--- tb_stopwatch_timer.sv
// self-checking testbench for the stopwatch timer
`timescale 1ns/1ns
module tb_stopwatch_timer
    import stopwatch_pkg::*;
;
    logic CLK_IN = 1'b0;
    logic SYS_RST_IN = 1'b1;
    logic CE_IN = 1'b1;
    logic TICK_256_IN = 1'b0;
    logic [AW-1:0] AVS_ADDRESS_IN = '0;
    logic AVS_READ_IN = 1'b0;
    logic AVS_WRITE_IN = 1'b0;
    logic [DW-1:0] AVS_WRITEDATA_IN = '0;
    logic [3:0] AVS_BYTEENABLE_IN = 4'hF;
    logic [DW-1:0] AVS_READDATA_OUT;
    logic AVS_WAITREQUEST_OUT;
    logic IRQ_OUT;
    int fails = 0;
    int checks = 0;
    int pres = 0;
    int k;
    logic [3:0] lo = 4'h0;
    logic [3:0] hi = 4'h0;
    logic [1:0] flg = 2'h0;
    logic [1:0] en = 2'h0;
    logic run = 1'b0;
    logic [31:0] lfsr = 32'h000177D3;
    logic [DW-1:0] exp_q[$];

    stopwatch_timer stopwatch_timer_inst (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .CE_IN(CE_IN),
        .TICK_256_IN(TICK_256_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
        .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
        .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
        .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .IRQ_OUT(IRQ_OUT));

    always #4 CLK_IN = ~CLK_IN;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task stop_test;
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // read data checked against the oldest expectation
    always @(posedge CLK_IN) begin
        if (AVS_READ_IN === 1'b1 && AVS_WAITREQUEST_OUT === 1'b0) begin
            checks++;
            if (exp_q.size() == 0 || AVS_READDATA_OUT !== exp_q[0]) begin
                fails++;
                $display("[FAIL] %0t read data %h", $time, AVS_READDATA_OUT);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end

    task bus(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge CLK_IN);
        AVS_ADDRESS_IN <= a;
        AVS_READ_IN <= !wr;
        AVS_WRITE_IN <= wr;
        AVS_WRITEDATA_IN <= d;
        AVS_BYTEENABLE_IN <= be;
        // waitrequest sampled at the rising edge, request held until then
        do begin
            @(posedge CLK_IN);
            n++;
        end while (AVS_WAITREQUEST_OUT !== 1'b0 && n < 50);
        if (n >= 50) begin
            fails++;
            $display("[FAIL] %0t bus answer missing", $time);
            stop_test;
        end
        AVS_READ_IN <= 1'b0;
        AVS_WRITE_IN <= 1'b0;
    endtask

    task rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, {DW{1'b1}}, 4'hF);
    endtask

    task wr(input logic [AW-1:0] a, input logic [3:0] d);
        bus(1'b1, a, {28'hFFFFFF0, d}, 4'h1);
    endtask

    task clr;
        lo = 4'h0;
        hi = 4'h0;
        pres = 0;
    endtask

    task chk_irq;
        @(negedge CLK_IN);
        checks++;
        if (IRQ_OUT !== |(flg & en)) begin
            fails++;
            $display("[FAIL] %0t interrupt level %b", $time, IRQ_OUT);
        end
    endtask

    task rdall;
        rd(HUND_ADDR, {28'h0, lo});
        rd(TENTH_ADDR, {28'h0, hi});
        rd(IRQ_EN_ADDR, {30'h0, en});
        rd(IRQ_FLAG_ADDR, {30'h0, flg});
        rd(CTRL_ADDR, {31'h0, run});
        chk_irq;
    endtask

    // reference count: step after three ticks on odd digit or long decade start
    task tick(input int n);
        repeat (n) begin
            @(posedge CLK_IN);
            TICK_256_IN <= 1'b1;
            @(posedge CLK_IN);
            TICK_256_IN <= 1'b0;
            if (run && CE_IN) begin
                pres++;
                if (pres == ((lo[0] || (lo == 4'h0 && hi >= 4'h4)) ? 3 : 2)) begin
                    pres = 0;
                    lo = lo + 4'h1;
                    if (lo == 4'hA) begin
                        lo = 4'h0;
                        flg[0] = 1'b1;
                        hi = hi + 4'h1;
                        if (hi == 4'hA) begin
                            hi = 4'h0;
                            flg[1] = 1'b1;
                        end
                    end
                end
            end
        end
    endtask

    initial begin
        #100000;
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test;
    end

    initial begin
        repeat (6) @(posedge CLK_IN);
        SYS_RST_IN <= 1'b0;
        rdall;
        rd(18'h00100, 32'h0);
        wr(HUND_ADDR, 4'h5);
        wr(TENTH_ADDR, 4'h7);
        bus(1'b1, IRQ_EN_ADDR, 32'h3, 4'hE);
        rdall;
        wr(CTRL_ADDR, 4'h1);
        run = 1'b1;
        lfsr = lfsr_next(lfsr);
        k = int'(lfsr[4:0]) + 1;
        tick(k);
        rdall;
        tick(256 - k);
        rdall;
        wr(IRQ_EN_ADDR, 4'h2);
        en = 2'h2;
        chk_irq;
        wr(IRQ_FLAG_ADDR, 4'h1);
        flg[0] = 1'b0;
        wr(IRQ_FLAG_ADDR, 4'h0);
        rdall;
        wr(IRQ_FLAG_ADDR, 4'h2);
        flg = 2'h0;
        rdall;
        tick(7);
        wr(CTRL_ADDR, 4'h0);
        run = 1'b0;
        tick(9);
        rdall;
        wr(CTRL_ADDR, 4'h1);
        run = 1'b1;
        tick(3);
        CE_IN <= 1'b0;
        tick(4);
        CE_IN <= 1'b1;
        wr(CTRL_ADDR, 4'h0);
        run = 1'b0;
        rdall;
        wr(CTRL_ADDR, 4'h2);
        clr;
        tick(5);
        rdall;
        wr(CTRL_ADDR, 4'h1);
        run = 1'b1;
        tick(4);
        wr(CTRL_ADDR, 4'h3);
        clr;
        tick(2);
        rdall;
        @(posedge CLK_IN);
        SYS_RST_IN <= 1'b1;
        @(posedge CLK_IN);
        SYS_RST_IN <= 1'b0;
        clr;
        run = 1'b0;
        en = 2'h0;
        flg = 2'h0;
        rdall;
        stop_test;
    end
endmodule // tb_stopwatch_timer
